// *** hdl/ebp_lane_strobe.sv ***
// Byte-lane strobe coding for the static device organisations
`timescale 1ns/100ps
`include "ebp_params.svh"

module ebp_lane_strobe
(
   input wire ebp_pkg::ebp_width_t mode_i,
   input wire logic active_i,
   input wire logic wr_i,
   input wire logic [1:0] addr_lo_i,
   input wire logic [`EBP_LANES-1:0] lanes_i,
   output logic a0_o,
   output logic a1_o,
   output logic wr0_n_o,
   output logic wr1_n_o,
   output logic wr3_n_o
);

   logic [`EBP_LANES-1:0] wr_lane;
   logic [`EBP_LANES-1:0] sel_lane;

   // Lane strobes exist only inside an access
   assign wr_lane = (active_i && wr_i) ? lanes_i : 4'h0;
   assign sel_lane = active_i ? lanes_i : 4'h0;

   always_comb
   begin
      a0_o = addr_lo_i[0];
      a1_o = addr_lo_i[1];
      wr0_n_o = ~(active_i && wr_i);
      wr1_n_o = 1'b1;
      wr3_n_o = 1'b1;
      case (mode_i)
         ebp_pkg::EBP_W8:
         begin
            wr0_n_o = ~(active_i && wr_i);
         end
         ebp_pkg::EBP_W2X8:
         begin
            wr0_n_o = ~wr_lane[0];
            wr1_n_o = ~wr_lane[1];
         end
         ebp_pkg::EBP_W16:
         begin
            a0_o = ~sel_lane[0];
            wr1_n_o = ~sel_lane[1];
         end
         ebp_pkg::EBP_W4X8:
         begin
            wr0_n_o = ~wr_lane[0];
            wr1_n_o = ~wr_lane[1];
            a1_o = ~wr_lane[2];
            wr3_n_o = ~wr_lane[3];
         end
         ebp_pkg::EBP_W2X16, ebp_pkg::EBP_W32:
         begin
            // Same pins whether two halves or one wide device
            a0_o = ~sel_lane[0];
            wr1_n_o = ~sel_lane[1];
            a1_o = ~sel_lane[2];
            wr3_n_o = ~sel_lane[3];
         end
         default:
         begin
            wr0_n_o = 1'b1;
         end
      endcase
   end

endmodule : ebp_lane_strobe

// *** hdl/ebp_params.svh ***
// Constants for the external bus pin-sharing block
`ifndef EBP_PARAMS_SVH
`define EBP_PARAMS_SVH

// =====================================================================
// Widths
`define EBP_ADDR_W 26
`define EBP_DATA_W 32
`define EBP_LANES 4
`define EBP_NCS 6
`define EBP_DRAM_ADDR_W 13
`define EBP_BANK_W 2

// =====================================================================
// Shared address pin positions
`define EBP_DRAM_LO_PIN 2
`define EBP_DRAM_LO_W 10
`define EBP_DRAM_A10 10
`define EBP_DRAM_HI_PIN 13
`define EBP_DRAM_HI_SRC 11
`define EBP_DRAM_HI_W 2

// =====================================================================
// Reset values of the pins
`define EBP_RST_ADDR 26'h000_0000
`define EBP_RST_DATA 32'h0000_0000
`define EBP_RST_NCS 6'h3F
`define EBP_RST_LANES 4'hF
`define EBP_RST_BANK 2'h0

`endif

// *** hdl/ebp_pin_share.sv ***
// Shared external pins between static and synchronous DRAM controllers
//
// Functional notes
// - Each shared pin except address pins 0, 1 and 12 follows whichever controller owns the bus, some through selection logic.
// - With two byte-wide write-strobed devices, strobe 1 falls only for upper and 0 for lower.
// - With four byte-wide devices, write strobe x falls only when lane x is written.
// - In byte-select mode, selects 0 and 1 enable the two bytes of the lower half-word.
// - In byte-select mode, selects 2 and 3 enable the two bytes of the upper half-word.
// - A single 32-bit device gets four lane enables, each enabling only its own byte.
// - A dedicated active-low DRAM chip select falls only for DRAM accesses.
// - An active-low NAND chip select falls only while a NAND access is running.
// - NAND read and write enables are their own active-low pins, apart from static strobes.
// - DRAM address bit 10 leaves on its own pin, not on the static address bus.
`timescale 1ns/100ps
`include "ebp_params.svh"

module ebp_pin_share
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic dram_owns_i,
   input wire ebp_pkg::ebp_width_t width_mode_i,
   input wire ebp_pkg::ebp_smc_t smc_i,
   input wire ebp_pkg::ebp_dram_t dram_i,
   input wire logic ext_wait_n_i,
   input wire logic [`EBP_DATA_W-1:0] data_i,
   output ebp_pkg::ebp_pins_t pins_o,
   output logic [`EBP_DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   output logic [`EBP_DATA_W-1:0] rdata_o,
   output logic ext_wait_o
);

   // =====================================================================
   // Next pin values
   ebp_pkg::ebp_pins_t pins_r;
   ebp_pkg::ebp_pins_t pins_nxt;
   logic [`EBP_DATA_W-1:0] data_r;
   logic data_oe_n_r;
   logic [`EBP_DATA_W-1:0] rdata_r;
   logic wait_r;
   logic smc_active;
   logic nand_active;
   logic lane_a0;
   logic lane_a1;
   logic lane_wr0_n;
   logic lane_wr1_n;
   logic lane_wr3_n;

   // The NAND access is a static access on its own strobes
   assign nand_active = !dram_owns_i && smc_i.nand_acc;
   assign smc_active = !dram_owns_i && (|smc_i.cs) && !smc_i.nand_acc;

   ebp_lane_strobe u_lane
   (
      .mode_i(width_mode_i),
      .active_i(smc_active),
      .wr_i(smc_i.wr),
      .addr_lo_i(smc_i.addr[1:0]),
      .lanes_i(smc_i.lanes),
      .a0_o(lane_a0),
      .a1_o(lane_a1),
      .wr0_n_o(lane_wr0_n),
      .wr1_n_o(lane_wr1_n),
      .wr3_n_o(lane_wr3_n)
   );

   always_comb
   begin
      pins_nxt = pins_r;
      pins_nxt.addr = smc_i.addr;
      pins_nxt.addr[0] = lane_a0;
      pins_nxt.addr[1] = lane_a1;
      pins_nxt.static_chip_sel_n = dram_owns_i ? `EBP_RST_NCS : ~smc_i.cs;
      pins_nxt.rd_n = ~(smc_active && smc_i.rd);
      pins_nxt.wr0_n = lane_wr0_n;
      pins_nxt.wr1_n = lane_wr1_n;
      pins_nxt.wr3_n = lane_wr3_n;
      pins_nxt.nand_chip_sel_n = ~nand_active;
      pins_nxt.nand_read_en_n = ~(nand_active && smc_i.rd);
      pins_nxt.nand_write_en_n = ~(nand_active && smc_i.wr);
      pins_nxt.dram_chip_sel_n = ~(dram_owns_i && dram_i.cs);
      pins_nxt.dram_addr_bit10 = dram_i.addr[`EBP_DRAM_A10];
      pins_nxt.ras_n = ~(dram_owns_i && dram_i.ras);
      pins_nxt.cas_n = ~(dram_owns_i && dram_i.cas);
      pins_nxt.dram_we_n = ~(dram_owns_i && dram_i.we);
      pins_nxt.bank = dram_i.bank;
      pins_nxt.cke = dram_i.cke;
      pins_nxt.dqm = dram_i.dqm;
      if (dram_owns_i)
      begin
         // Bit 10 and pin 12 are skipped on the shared address bus
         pins_nxt.addr[`EBP_DRAM_LO_PIN +: `EBP_DRAM_LO_W] =
            dram_i.addr[0 +: `EBP_DRAM_LO_W];
         pins_nxt.addr[`EBP_DRAM_HI_PIN +: `EBP_DRAM_HI_W] =
            dram_i.addr[`EBP_DRAM_HI_SRC +: `EBP_DRAM_HI_W];
         pins_nxt.wr1_n = dram_i.dqm[1];
         pins_nxt.wr0_n = 1'b1;
         pins_nxt.wr3_n = 1'b1;
      end
   end

   // =====================================================================
   // Pin registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pins_r.addr <= `EBP_RST_ADDR;
         pins_r.dram_addr_bit10 <= 1'b0;
         pins_r.static_chip_sel_n <= `EBP_RST_NCS;
         pins_r.dram_chip_sel_n <= 1'b1;
         pins_r.rd_n <= 1'b1;
         pins_r.wr0_n <= 1'b1;
         pins_r.wr1_n <= 1'b1;
         pins_r.wr3_n <= 1'b1;
         pins_r.nand_chip_sel_n <= 1'b1;
         pins_r.nand_read_en_n <= 1'b1;
         pins_r.nand_write_en_n <= 1'b1;
         pins_r.ras_n <= 1'b1;
         pins_r.cas_n <= 1'b1;
         pins_r.dram_we_n <= 1'b1;
         pins_r.bank <= `EBP_RST_BANK;
         pins_r.cke <= 1'b0;
         pins_r.dqm <= `EBP_RST_LANES;
      end
      else
      begin
         pins_r <= pins_nxt;
      end
   end

   // Data bus goes to whichever controller owns it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         data_r <= `EBP_RST_DATA;
         data_oe_n_r <= 1'b1;
      end
      else
      begin
         data_r <= dram_owns_i ? dram_i.wdata : smc_i.wdata;
         data_oe_n_r <= dram_owns_i ? !dram_i.drive : !smc_i.drive;
      end
   end

   // Read data and wait level, sampled once
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_r <= `EBP_RST_DATA;
         wait_r <= 1'b0;
      end
      else
      begin
         rdata_r <= data_i;
         wait_r <= !ext_wait_n_i && !dram_owns_i;
      end
   end

   assign pins_o = pins_r;
   assign data_o = data_r;
   assign data_oe_n_o = data_oe_n_r;
   assign rdata_o = rdata_r;
   assign ext_wait_o = wait_r;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_OWNER_DATA: assert property (
      !dram_owns_i && smc_i.drive |=> !data_oe_n_o && data_o == $past(smc_i.wdata))
      else $error("Static data not on bus while static owns it");
   AST_TWO_BYTE_WR: assert property (
      width_mode_i == ebp_pkg::EBP_W2X8 && smc_active && smc_i.wr
      |=> pins_o.wr1_n == !$past(smc_i.lanes[1]) && pins_o.wr0_n == !$past(smc_i.lanes[0]))
      else $error("Byte write strobe does not match written byte");
   AST_FOUR_BYTE_WR: assert property (
      width_mode_i == ebp_pkg::EBP_W4X8 && smc_active
      |=> pins_o.wr0_n == !$past(smc_i.wr && smc_i.lanes[0])
         && pins_o.wr1_n == !$past(smc_i.wr && smc_i.lanes[1])
         && pins_o.addr[1] == !$past(smc_i.wr && smc_i.lanes[2])
         && pins_o.wr3_n == !$past(smc_i.wr && smc_i.lanes[3]))
      else $error("Lane write strobe does not match written lane");
   AST_SEL_LOW: assert property (
      width_mode_i == ebp_pkg::EBP_W16 && smc_active
      |=> pins_o.addr[0] == !$past(smc_i.lanes[0]) && pins_o.wr1_n == !$past(smc_i.lanes[1]))
      else $error("Lower half-word selects wrong");
   AST_SEL_HIGH: assert property (
      width_mode_i == ebp_pkg::EBP_W2X16 && smc_active
      |=> pins_o.addr[1] == !$past(smc_i.lanes[2]) && pins_o.wr3_n == !$past(smc_i.lanes[3]))
      else $error("Upper half-word selects wrong");
   AST_WIDE_ENABLES: assert property (
      width_mode_i == ebp_pkg::EBP_W32 && smc_active
      |=> pins_o.addr[0] == !$past(smc_i.lanes[0]) && pins_o.wr1_n == !$past(smc_i.lanes[1])
         && pins_o.addr[1] == !$past(smc_i.lanes[2]) && pins_o.wr3_n == !$past(smc_i.lanes[3]))
      else $error("Lane enable not limited to its own byte");
   AST_DRAM_CS: assert property (
      !pins_o.dram_chip_sel_n |-> $past(dram_owns_i) && $past(dram_i.cs))
      else $error("DRAM select without DRAM access");
   AST_NAND_CS: assert property (
      !pins_o.nand_chip_sel_n |-> $past(smc_i.nand_acc) && !$past(dram_owns_i))
      else $error("NAND select without NAND access");
   AST_NAND_STROBES: assert property (
      !pins_o.nand_read_en_n || !pins_o.nand_write_en_n |-> pins_o.rd_n && pins_o.wr0_n)
      else $error("NAND strobe shared with static strobe");
   AST_BIT10: assert property (
      dram_owns_i ##1 dram_owns_i |-> pins_o.dram_addr_bit10 == $past(dram_i.addr[10]))
      else $error("DRAM address bit 10 lost");
   AST_ADDR_MUX: assert property (
      dram_owns_i |=> pins_o.addr[11:2] == $past(dram_i.addr[9:0])
         && pins_o.addr[14:13] == $past(dram_i.addr[12:11])
         && pins_o.addr[12] == $past(smc_i.addr[12]))
      else $error("Shared address pins not from DRAM");

   COV_DRAM_ACC: cover property (dram_owns_i && dram_i.cs ##1 !pins_o.dram_chip_sel_n);
   COV_NAND_WR: cover property (nand_active && smc_i.wr ##1 !pins_o.nand_write_en_n);
   COV_OWNER_SWAP: cover property (dram_owns_i ##1 !dram_owns_i ##1 smc_active);
   COV_QUAD_WR: cover property (width_mode_i == ebp_pkg::EBP_W4X8 && smc_active && smc_i.wr);

endmodule : ebp_pin_share

// *** hdl/ebp_pkg.sv ***
// Types of the external bus pin-sharing block
`include "ebp_params.svh"

package ebp_pkg;

   // =====================================================================
   // Static device organisation on the shared bus
   typedef enum logic [2:0] {
      EBP_W8,
      EBP_W2X8,
      EBP_W16,
      EBP_W4X8,
      EBP_W2X16,
      EBP_W32
   } ebp_width_t;

   // Static controller request, active high
   typedef struct packed {
      logic [`EBP_ADDR_W-1:0] addr;
      logic [`EBP_NCS-1:0] cs;
      logic rd;
      logic wr;
      logic [`EBP_LANES-1:0] lanes;
      logic nand_acc;
      logic drive;
      logic [`EBP_DATA_W-1:0] wdata;
   } ebp_smc_t;

   // DRAM controller request, active high
   typedef struct packed {
      logic [`EBP_DRAM_ADDR_W-1:0] addr;
      logic [`EBP_BANK_W-1:0] bank;
      logic cs;
      logic ras;
      logic cas;
      logic we;
      logic cke;
      logic [`EBP_LANES-1:0] dqm;
      logic drive;
      logic [`EBP_DATA_W-1:0] wdata;
   } ebp_dram_t;

   // External pins, strobes active low
   typedef struct packed {
      logic [`EBP_ADDR_W-1:0] addr;
      logic dram_addr_bit10;
      logic [`EBP_NCS-1:0] static_chip_sel_n;
      logic dram_chip_sel_n;
      logic rd_n;
      logic wr0_n;
      logic wr1_n;
      logic wr3_n;
      logic nand_chip_sel_n;
      logic nand_read_en_n;
      logic nand_write_en_n;
      logic ras_n;
      logic cas_n;
      logic dram_we_n;
      logic [`EBP_BANK_W-1:0] bank;
      logic cke;
      logic [`EBP_LANES-1:0] dqm;
   } ebp_pins_t;

endpackage : ebp_pkg

// *** sim/ebp_ext_mem_model.sv ***
// Behavioural model of the memories behind the shared pins
`timescale 1ns/100ps
`include "ebp_params.svh"

module ebp_ext_mem_model
(
   input wire logic clk_i,
   input wire ebp_pkg::ebp_pins_t pins_i,
   input wire logic [`EBP_DATA_W-1:0] wdata_i,
   output logic [`EBP_DATA_W-1:0] rdata_o
);
   logic [`EBP_DATA_W-1:0] mem [16];
   logic rd_act;
   logic wr_act;
   logic [3:0] idx;

   assign idx = pins_i.addr[5:2];
   assign rd_act = (!pins_i.rd_n && !(&pins_i.static_chip_sel_n)) || !pins_i.nand_read_en_n
      || (!pins_i.dram_chip_sel_n && !pins_i.cas_n && pins_i.dram_we_n);
   assign wr_act = !pins_i.wr0_n && !(&pins_i.static_chip_sel_n);

   initial
   begin
      for (int i = 0; i < 16; i++)
         mem[i] = 32'hA5C3_0000 + 32'(i);
      rdata_o = 32'h0000_0000;
   end

   // Released bus toggles so stale data never looks valid
   always @(negedge clk_i)
   begin
      if (wr_act)
         mem[idx] <= wdata_i;
      rdata_o <= rd_act ? mem[idx] : ~rdata_o;
   end
endmodule : ebp_ext_mem_model

// *** sim/ext_bus_pin_sharing_tb_top.sv ***
// Self-checking bench of the shared external pin logic
`timescale 1ns/100ps
`include "ebp_params.svh"

module ext_bus_pin_sharing_tb_top;
   typedef struct {
      ebp_pkg::ebp_pins_t p;
      logic oe_n;
      logic [31:0] d;
      logic w;
      logic r;
   } ebp_note_t;

   logic clk_i;
   logic rst_i;
   logic own;
   ebp_pkg::ebp_width_t mode;
   ebp_pkg::ebp_smc_t s;
   ebp_pkg::ebp_dram_t dr;
   logic wait_n;
   logic [31:0] data_i;
   logic [31:0] mdl_d;
   ebp_pkg::ebp_pins_t pins_o;
   logic [31:0] data_o;
   logic oe_n;
   logic [31:0] rdata_o;
   logic wait_o;
   ebp_note_t notes[$];
   int fail_count;
   int samples_checked;
   int cyc;
   logic [31:0] x;

   assign data_i = oe_n ? mdl_d : data_o;

   ebp_pin_share i_dut (.clk_i(clk_i), .rst_i(rst_i), .dram_owns_i(own), .width_mode_i(mode),
      .smc_i(s), .dram_i(dr), .ext_wait_n_i(wait_n), .data_i(data_i), .pins_o(pins_o),
      .data_o(data_o), .data_oe_n_o(oe_n), .rdata_o(rdata_o), .ext_wait_o(wait_o));

   ebp_ext_mem_model i_mem (.clk_i(clk_i), .pins_i(pins_o), .wdata_i(data_o), .rdata_o(mdl_d));

   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // =====================================================================
   // Reference pin values
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return (v >> 1) ^ (v[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction : lfsr

   function automatic ebp_pkg::ebp_pins_t calc(input logic rst);
      ebp_pkg::ebp_pins_t p;
      logic g;
      logic w;
      logic [3:0] l;
      g = !own && !s.nand_acc && (|s.cs);
      w = s.wr && g;
      l = s.lanes;
      p = '1;
      p.addr = rst ? '0 : s.addr;
      p.dram_addr_bit10 = rst ? 1'b0 : dr.addr[10];
      p.bank = rst ? 2'h0 : dr.bank;
      p.cke = rst ? 1'b0 : dr.cke;
      p.dqm = rst ? 4'hF : dr.dqm;
      if (rst)
         return p;
      if (g)
      begin
         p.static_chip_sel_n = ~s.cs;
         p.rd_n = ~s.rd;
      end
      p.wr0_n = ~w;
      case (mode)
         ebp_pkg::EBP_W8: ;
         ebp_pkg::EBP_W2X8:
         begin
            p.wr0_n = ~(w & l[0]);
            p.wr1_n = ~(w & l[1]);
         end
         ebp_pkg::EBP_W4X8:
         begin
            p.wr0_n = ~(w & l[0]);
            p.wr1_n = ~(w & l[1]);
            p.addr[1] = ~(w & l[2]);
            p.wr3_n = ~(w & l[3]);
         end
         ebp_pkg::EBP_W16:
         begin
            p.addr[0] = ~(g & l[0]);
            p.wr1_n = ~(g & l[1]);
         end
         default:
         begin
            p.addr[0] = ~(g & l[0]);
            p.wr1_n = ~(g & l[1]);
            p.addr[1] = ~(g & l[2]);
            p.wr3_n = ~(g & l[3]);
         end
      endcase
      if (!own && s.nand_acc)
      begin
         p.nand_chip_sel_n = 1'b0;
         p.nand_read_en_n = ~s.rd;
         p.nand_write_en_n = ~s.wr;
      end
      if (own)
      begin
         p.addr[11:2] = dr.addr[9:0];
         p.addr[14:13] = dr.addr[12:11];
         p.wr1_n = dr.dqm[1];
         p.dram_chip_sel_n = ~dr.cs;
         p.ras_n = ~dr.ras;
         p.cas_n = ~dr.cas;
         p.dram_we_n = ~dr.we;
      end
      return p;
   endfunction : calc

   // =====================================================================
   // Driver: new random inputs each falling edge, expectation queued
   task automatic step(input logic rst);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      ebp_note_t n;
      @(negedge clk_i);
      x = lfsr(x);
      a = x;
      x = lfsr(x);
      b = x;
      x = lfsr(x);
      c = x;
      rst_i = rst;
      own = a[31];
      mode = ebp_pkg::ebp_width_t'(3'(a[30:28] % 3'h6));
      s.addr = a[25:0];
      s.nand_acc = a[27] & a[26];
      s.cs = (s.nand_acc || b[3]) ? 6'h00 : 6'h01 << (b[2:0] % 3'h6);
      s.wr = b[5] & ((|s.cs) | s.nand_acc);
      s.rd = ~b[5] & b[6] & ((|s.cs) | s.nand_acc);
      s.lanes = b[10:7];
      s.drive = b[11];
      s.wdata = c;
      dr = {b[24:12], b[26:25], b[27], b[28], b[29], b[30], b[31], a[3:0] ^ c[3:0],
         c[31] ^ a[0], ~c};
      wait_n = c[4];
      n.p = calc(rst);
      n.oe_n = rst | (own ? ~dr.drive : ~s.drive);
      n.d = rst ? 32'h0000_0000 : (own ? dr.wdata : s.wdata);
      n.w = !rst && !own && !wait_n;
      n.r = rst;
      notes.push_back(n);
   endtask : step

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // =====================================================================
   // Monitor: one result per rising edge
   always @(posedge clk_i)
   begin : mon
      ebp_note_t n;
      ebp_pkg::ebp_pins_t got;
      logic [31:0] dq;
      dq = data_i;
      #1;
      if (notes.size() > 0)
      begin
         n = notes.pop_front();
         got = pins_o;
         chk(128'(got), 128'(n.p));
         chk(128'(oe_n), 128'(n.oe_n));
         if (n.r || !n.oe_n)
            chk(128'(data_o), 128'(n.d));
         chk(128'(wait_o), 128'(n.w));
         chk(128'(rdata_o), n.r ? 128'h0 : 128'(dq));
      end
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Hang guard well above the roughly 611 cycles of stimulus
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         test_done();
      end
   end

   initial
   begin
      fail_count = 0;
      samples_checked = 0;
      cyc = 0;
      x = 32'h0001_2FEF;
      rst_i = 1'b1;
      own = 1'b0;
      mode = ebp_pkg::EBP_W8;
      s = '0;
      dr = '0;
      wait_n = 1'b1;
      repeat (8) step(1'b1);
      for (int i = 0; i < 600; i++)
         step(i == 300 || i == 301);
      repeat (3) @(posedge clk_i);
      #5;
      test_done();
   end
endmodule : ext_bus_pin_sharing_tb_top
